// >>> core/cxu_pkg.sv
// shared constants and carrier types for the execution unit
// assumes an ahb-lite master on clk_sys and a single slave on the bus
package cxu_pkg;

   // ahb-lite request as seen by the slave
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } cxu_ahb_req_s;

   // ahb-lite answer of the slave
   typedef struct packed {
      logic        hreadyout;
      logic [31:0] hrdata;
      logic        hresp;
   } cxu_ahb_rsp_s;

   // one-cycle pulses for the control instructions
   typedef struct packed {
      logic brk;
      logic sleep;
      logic watchdog_restart;
   } cxu_evt_s;

   // operation codes, low five bits of the command word
   typedef enum logic [4:0] {
      OP_NOP                    = 5'h00,
      OP_IO_READ                = 5'h01,
      OP_IO_WRITE               = 5'h02,
      OP_STACK_PUSH             = 5'h03,
      OP_STACK_POP              = 5'h04,
      OP_EXCHANGE_MEMORY        = 5'h05,
      OP_LOAD_AND_OR_MEMORY     = 5'h06,
      OP_LOAD_AND_CLEAR_MEMORY  = 5'h07,
      OP_LOAD_AND_TOGGLE_MEMORY = 5'h08,
      OP_LOGICAL_SHIFT_LEFT     = 5'h09,
      OP_LOGICAL_SHIFT_RIGHT    = 5'h0A,
      OP_ROTATE_LEFT_CARRY      = 5'h0B,
      OP_ROTATE_RIGHT_CARRY     = 5'h0C,
      OP_ARITH_SHIFT_RIGHT      = 5'h0D,
      OP_SWAP_NIBBLES           = 5'h0E,
      OP_FLAG_BIT_SET           = 5'h0F,
      OP_FLAG_BIT_CLEAR         = 5'h10,
      OP_SET_IO_BIT             = 5'h11,
      OP_CLEAR_IO_BIT           = 5'h12,
      OP_STORE_BIT_TO_T         = 5'h13,
      OP_LOAD_BIT_FROM_T        = 5'h14,
      OP_BREAK                  = 5'h15,
      OP_SLEEP                  = 5'h16,
      OP_WATCHDOG_RESTART       = 5'h17
   } cxu_op_e;

   // command word layout
   typedef struct packed {
      logic [12:0] unused;
      logic [2:0]  bit_sel;
      logic [5:0]  io_addr;
      logic [4:0]  reg_sel;
      cxu_op_e     op;
   } cxu_cmd_s;

   // execution sequencer, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } cxu_state_e;

   // status_flags bit positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   // register map, byte offsets within the slave window
   localparam logic [11:0] OFS_CMD    = 12'h000;
   localparam logic [11:0] OFS_FLAGS  = 12'h004;
   localparam logic [11:0] OFS_ZPTR   = 12'h008;
   localparam logic [11:0] OFS_SPTR   = 12'h00C;
   localparam logic [11:0] OFS_CTRL   = 12'h010;
   localparam logic [3:0]  PAGE_GPR   = 4'h1;
   localparam logic [3:0]  PAGE_IO    = 4'h2;
   localparam logic [2:0]  PAGE_DMEM  = 3'h1;
   localparam int unsigned CMD_BUSY   = 31;
   localparam int unsigned CTRL_EXT   = 0;

   // values after reset
   localparam logic [7:0]  SPTR_RST   = 8'hFF;
   localparam logic [7:0]  FLAGS_RST  = 8'h00;

   // cycle counts
   localparam logic [2:0]  CYC_ONE    = 3'h1;
   localparam logic [2:0]  CYC_TWO    = 3'h2;
   localparam logic [2:0]  CYC_EXT    = 3'h2;
   localparam logic [2:0]  CYC_SRAM   = 3'h1;

endpackage : cxu_pkg

// >>> core/cxu_core.sv
// execution unit for i/o transfer, stack, atomic memory, shift and
// flag instructions, with register file, i/o space and data memory
// assumes a single ahb-lite master on clk_sys, word accesses only
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - i/o read or write, one cycle, flags kept
// - push takes one cycle, flags kept
// - pop takes two cycles, flags kept
// - exchange and or-memory, load old, two cycles
// - clear-memory writes old and not register
// - toggle-memory writes register xor old memory
// - left shift and rotate, five flags updated
// - right shifts, zero carry negative overflow updated
// - set or clear one i/o bit, one cycle
// - copy register bit into t flag
// - copy t flag into register bit
// - single flag set or clear, others kept
// - t and half-carry set or clear alone
// - control instructions one cycle, no flags
// - external memory accesses may take longer
// - footnoted sram reads add one cycle
module cxu_core (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   // register bus
   input  wire cxu_pkg::cxu_ahb_req_s ahb_req,
   output var  cxu_pkg::cxu_ahb_rsp_s ahb_rsp,
   // control instruction pulses
   output var  cxu_pkg::cxu_evt_s     evt
);

   ////////////////////////////////////////////////////////////////////
   // state

   // whole state of the unit in one record
   typedef struct packed {
      cxu_pkg::cxu_state_e   st;       // sequencer
      logic [2:0]            cnt;      // cycles left minus one
      cxu_pkg::cxu_cmd_s     cmd;      // instruction in flight
      logic [7:0]            flags;    // status_flags
      logic [7:0]            zptr;     // z pointer
      logic [7:0]            sptr;     // stack pointer
      logic                  ext_mem;  // data memory seen as external
      logic [31:0][7:0]      gpr;      // register file
      logic [63:0][7:0]      io;       // i/o space
      logic [255:0][7:0]     dmem;     // data memory
      logic                  pend;     // bus data phase open
      logic                  wr;       // pending access is a write
      logic [11:0]           addr;     // pending byte offset
      cxu_pkg::cxu_ahb_rsp_s rsp;      // bus answer
      cxu_pkg::cxu_evt_s     evt;      // control pulses
   } cxu_core_s;

   cxu_core_s state_ff;  // registered state
   cxu_core_s nxt_state; // next state

   ////////////////////////////////////////////////////////////////////
   // next-state logic

   // one process decodes the bus and executes the instruction
   always_comb begin
      logic [7:0] rd;     // register operand
      logic [7:0] mv;     // old memory byte at z
      logic [7:0] res;    // shift result
      logic       cout;   // carry out of a shift
      logic [2:0] cyc;    // cycles for a new instruction
      logic       take;   // address phase accepted
      logic [31:0] rdat;  // read data mux
      cxu_pkg::cxu_cmd_s c;
      rd   = state_ff.gpr[state_ff.cmd.reg_sel];
      mv   = state_ff.dmem[state_ff.zptr];
      res  = 8'h00;
      cout = 1'b0;
      cyc  = cxu_pkg::CYC_ONE;
      take = 1'b0;
      rdat = 32'h0000_0000;
      c    = cxu_pkg::cxu_cmd_s'(state_ff.cmd);
      nxt_state = state_ff;
      // pulses last one cycle only
      nxt_state.evt = '0;
      nxt_state.rsp.hresp = 1'b0;

      // instruction execution, effect lands in the last cycle
      case (state_ff.st)
         cxu_pkg::ST_IDLE: begin
            nxt_state.st = cxu_pkg::ST_IDLE;
         end
         cxu_pkg::ST_EXEC: begin
            if (state_ff.cnt != 3'h0) begin
               // waiting out the extra cycles
               nxt_state.cnt = state_ff.cnt - 3'h1;
            end else begin
               nxt_state.st = cxu_pkg::ST_IDLE;
               case (state_ff.cmd.op)
                  cxu_pkg::OP_IO_READ: begin
                     nxt_state.gpr[c.reg_sel] = state_ff.io[c.io_addr];
                  end
                  cxu_pkg::OP_IO_WRITE: begin
                     nxt_state.io[c.io_addr] = rd;
                  end
                  cxu_pkg::OP_STACK_PUSH: begin
                     nxt_state.dmem[state_ff.sptr] = rd;
                     nxt_state.sptr = state_ff.sptr - 8'h01;
                  end
                  cxu_pkg::OP_STACK_POP: begin
                     nxt_state.sptr = state_ff.sptr + 8'h01;
                     nxt_state.gpr[c.reg_sel] =
                        state_ff.dmem[8'(state_ff.sptr + 8'h01)];
                  end
                  cxu_pkg::OP_EXCHANGE_MEMORY: begin
                     nxt_state.gpr[c.reg_sel] = mv;
                     nxt_state.dmem[state_ff.zptr] = rd;
                  end
                  cxu_pkg::OP_LOAD_AND_OR_MEMORY: begin
                     nxt_state.gpr[c.reg_sel] = mv;
                     nxt_state.dmem[state_ff.zptr] = rd | mv;
                  end
                  cxu_pkg::OP_LOAD_AND_CLEAR_MEMORY: begin
                     nxt_state.gpr[c.reg_sel] = mv;
                     nxt_state.dmem[state_ff.zptr] = (8'hFF - rd) & mv;
                  end
                  cxu_pkg::OP_LOAD_AND_TOGGLE_MEMORY: begin
                     nxt_state.gpr[c.reg_sel] = mv;
                     nxt_state.dmem[state_ff.zptr] = rd ^ mv;
                  end
                  // left shift, zero or carry enters bit 0
                  cxu_pkg::OP_LOGICAL_SHIFT_LEFT,
                  cxu_pkg::OP_ROTATE_LEFT_CARRY: begin
                     cout = rd[7];
                     res  = {rd[6:0],
                             (c.op == cxu_pkg::OP_ROTATE_LEFT_CARRY)
                             & state_ff.flags[cxu_pkg::FLAG_C]};
                     nxt_state.gpr[c.reg_sel] = res;
                     nxt_state.flags[cxu_pkg::FLAG_H] = rd[3];
                     nxt_state.flags[cxu_pkg::FLAG_C] = cout;
                     nxt_state.flags[cxu_pkg::FLAG_N] = res[7];
                     nxt_state.flags[cxu_pkg::FLAG_V] = res[7] ^ cout;
                     nxt_state.flags[cxu_pkg::FLAG_Z] = (res == 8'h00);
                  end
                  // right shifts differ only in bit 7
                  cxu_pkg::OP_LOGICAL_SHIFT_RIGHT,
                  cxu_pkg::OP_ROTATE_RIGHT_CARRY,
                  cxu_pkg::OP_ARITH_SHIFT_RIGHT: begin
                     cout = rd[0];
                     if (c.op == cxu_pkg::OP_ROTATE_RIGHT_CARRY) begin
                        res = {state_ff.flags[cxu_pkg::FLAG_C], rd[7:1]};
                     end else if (c.op == cxu_pkg::OP_ARITH_SHIFT_RIGHT)
                     begin
                        res = {rd[7], rd[7:1]};
                     end else begin
                        res = {1'b0, rd[7:1]};
                     end
                     nxt_state.gpr[c.reg_sel] = res;
                     nxt_state.flags[cxu_pkg::FLAG_C] = cout;
                     nxt_state.flags[cxu_pkg::FLAG_N] = res[7];
                     nxt_state.flags[cxu_pkg::FLAG_V] = res[7] ^ cout;
                     nxt_state.flags[cxu_pkg::FLAG_Z] = (res == 8'h00);
                  end
                  cxu_pkg::OP_SWAP_NIBBLES: begin
                     nxt_state.gpr[c.reg_sel] = {rd[3:0], rd[7:4]};
                  end
                  cxu_pkg::OP_FLAG_BIT_SET: begin
                     nxt_state.flags[c.bit_sel] = 1'b1;
                  end
                  cxu_pkg::OP_FLAG_BIT_CLEAR: begin
                     nxt_state.flags[c.bit_sel] = 1'b0;
                  end
                  cxu_pkg::OP_SET_IO_BIT: begin
                     nxt_state.io[c.io_addr][c.bit_sel] = 1'b1;
                  end
                  cxu_pkg::OP_CLEAR_IO_BIT: begin
                     nxt_state.io[c.io_addr][c.bit_sel] = 1'b0;
                  end
                  cxu_pkg::OP_STORE_BIT_TO_T: begin
                     nxt_state.flags[cxu_pkg::FLAG_T] = rd[c.bit_sel];
                  end
                  cxu_pkg::OP_LOAD_BIT_FROM_T: begin
                     nxt_state.gpr[c.reg_sel][c.bit_sel] =
                        state_ff.flags[cxu_pkg::FLAG_T];
                  end
                  cxu_pkg::OP_BREAK: begin
                     nxt_state.evt.brk = 1'b1;
                  end
                  cxu_pkg::OP_SLEEP: begin
                     nxt_state.evt.sleep = 1'b1;
                  end
                  cxu_pkg::OP_WATCHDOG_RESTART: begin
                     nxt_state.evt.watchdog_restart = 1'b1;
                  end
                  default: begin
                     // nop and unused codes do nothing
                     nxt_state.st = cxu_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            // illegal one-hot code recovers to idle
            nxt_state.st = cxu_pkg::ST_IDLE;
         end
      endcase

      // bus slave: every data phase gets one wait state, and waits
      // while an instruction runs so memories never see two writers
      take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
      if (state_ff.pend) begin
         if (state_ff.st == cxu_pkg::ST_IDLE) begin
            nxt_state.pend = 1'b0;
            nxt_state.rsp.hreadyout = 1'b1;
            if (state_ff.wr) begin
               case (state_ff.addr)
                  cxu_pkg::OFS_CMD: begin
                     c = cxu_pkg::cxu_cmd_s'(ahb_req.hwdata);
                     // two-cycle memory operations
                     if (c.op inside {cxu_pkg::OP_STACK_POP,
                                      cxu_pkg::OP_EXCHANGE_MEMORY,
                                      cxu_pkg::OP_LOAD_AND_OR_MEMORY,
                                      cxu_pkg::OP_LOAD_AND_CLEAR_MEMORY,
                                      cxu_pkg::OP_LOAD_AND_TOGGLE_MEMORY})
                     begin
                        cyc = cxu_pkg::CYC_TWO;
                     end
                     if (state_ff.ext_mem &&
                         c.op inside {[cxu_pkg::OP_STACK_PUSH:
                                       cxu_pkg::OP_LOAD_AND_TOGGLE_MEMORY]})
                     begin
                        cyc = cyc + cxu_pkg::CYC_EXT;
                     end
                     // none of these reads carries the
                     // footnote, so no sram penalty is added here
                     nxt_state.cmd = c;
                     nxt_state.cnt = cyc - 3'h1;
                     nxt_state.st  = cxu_pkg::ST_EXEC;
                  end
                  cxu_pkg::OFS_FLAGS: begin
                     nxt_state.flags = ahb_req.hwdata[7:0];
                  end
                  cxu_pkg::OFS_ZPTR: begin
                     nxt_state.zptr = ahb_req.hwdata[7:0];
                  end
                  cxu_pkg::OFS_SPTR: begin
                     nxt_state.sptr = ahb_req.hwdata[7:0];
                  end
                  cxu_pkg::OFS_CTRL: begin
                     nxt_state.ext_mem = ahb_req.hwdata[cxu_pkg::CTRL_EXT];
                  end
                  default: begin
                     // window pages, unmapped writes are dropped
                     if (state_ff.addr[11:8] == cxu_pkg::PAGE_GPR &&
                         state_ff.addr[7] == 1'b0) begin
                        nxt_state.gpr[state_ff.addr[6:2]] =
                           ahb_req.hwdata[7:0];
                     end else if (state_ff.addr[11:8] == cxu_pkg::PAGE_IO)
                     begin
                        nxt_state.io[state_ff.addr[7:2]] =
                           ahb_req.hwdata[7:0];
                     end else if (state_ff.addr[11:10] ==
                                  cxu_pkg::PAGE_DMEM[1:0]) begin
                        nxt_state.dmem[state_ff.addr[9:2]] =
                           ahb_req.hwdata[7:0];
                     end
                  end
               endcase
            end else begin
               case (state_ff.addr)
                  cxu_pkg::OFS_CMD:   rdat = 32'(state_ff.cmd);
                  cxu_pkg::OFS_FLAGS: rdat = {24'h0, state_ff.flags};
                  cxu_pkg::OFS_ZPTR:  rdat = {24'h0, state_ff.zptr};
                  cxu_pkg::OFS_SPTR:  rdat = {24'h0, state_ff.sptr};
                  cxu_pkg::OFS_CTRL:  rdat = {31'h0, state_ff.ext_mem};
                  default: begin
                     if (state_ff.addr[11:8] == cxu_pkg::PAGE_GPR &&
                         state_ff.addr[7] == 1'b0) begin
                        rdat = {24'h0, state_ff.gpr[state_ff.addr[6:2]]};
                     end else if (state_ff.addr[11:8] == cxu_pkg::PAGE_IO)
                     begin
                        rdat = {24'h0, state_ff.io[state_ff.addr[7:2]]};
                     end else if (state_ff.addr[11:10] ==
                                  cxu_pkg::PAGE_DMEM[1:0]) begin
                        rdat = {24'h0, state_ff.dmem[state_ff.addr[9:2]]};
                     end
                  end
               endcase
               nxt_state.rsp.hrdata = rdat;
            end
         end
      end else if (take) begin
         // open the data phase with one wait state
         nxt_state.pend = 1'b1;
         nxt_state.wr   = ahb_req.hwrite;
         nxt_state.addr = {ahb_req.haddr[11:2], 2'b00};
         nxt_state.rsp.hreadyout = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers

   // asynchronous reset to constants only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff               <= '0;
         state_ff.st            <= cxu_pkg::ST_IDLE;
         state_ff.flags         <= cxu_pkg::FLAGS_RST;
         state_ff.sptr          <= cxu_pkg::SPTR_RST;
         state_ff.rsp.hreadyout <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs straight from the state flip-flops
   assign ahb_rsp = state_ff.rsp;
   assign evt     = state_ff.evt;

endmodule : cxu_core

`default_nettype wire

// >>> verif/cxu_ahb_master.sv
// bus master model facing the execution unit's register bus
// assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/1ps
`default_nettype none
module cxu_ahb_master (
   // clock
   input  wire logic                  clk_sys,
   // register bus
   output var  cxu_pkg::cxu_ahb_req_s ahb_req,
   input  wire cxu_pkg::cxu_ahb_rsp_s ahb_rsp
);
   cxu_pkg::cxu_ahb_req_s drv;  // fields set by the tasks

   initial drv = '0;

   // single slave, so its ready is the bus ready
   always_comb begin
      ahb_req        = drv;
      ahb_req.hready = ahb_rsp.hreadyout;
   end

   // wait for an edge with ready high; values are taken just before it
   task automatic wait_rdy(output logic [31:0] q);
      logic rdy;
      rdy = 1'b0;
      q   = '0;
      while (!rdy) begin
         @(negedge clk_sys);
         rdy = (ahb_rsp.hreadyout === 1'b1);
         q   = ahb_rsp.hrdata;
         @(posedge clk_sys);
      end
   endtask : wait_rdy

   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      drv.hsel   <= 1'b1;
      drv.htrans <= 2'b10;
      drv.haddr  <= a;
      drv.hwrite <= w;
      drv.hsize  <= 3'h2;
      wait_rdy(q);
      // released address lines show garbage, not the old address
      drv.hsel   <= 1'b0;
      drv.htrans <= 2'b00;
      drv.haddr  <= ~a;
      drv.hwdata <= w ? d : ~d;
      wait_rdy(q);
      drv.hwdata <= ~d;
   endtask : xfer
endmodule : cxu_ahb_master
`default_nettype wire

// >>> verif/cxu_core_assertions.sv
// port-level checker for the execution unit
// assumes the bind below and the bus master's hready loop
`timescale 1ns/1ps
`default_nettype none
module cxu_core_assertions (
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  reset,
   // bus and events
   input wire cxu_pkg::cxu_ahb_req_s ahb_req,
   input wire cxu_pkg::cxu_ahb_rsp_s ahb_rsp,
   input wire cxu_pkg::cxu_evt_s     evt
);
   logic taken;  // address phase accepted at this edge

   assign taken = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_resp_okay: assert property (ahb_rsp.hresp == 1'b0)
      else $error("slave answered with an error response");
   a_take_stall: assert property (taken |=> !ahb_rsp.hreadyout)
      else $error("accepted transfer did not stall");
   a_wait_bound: assert property (taken |=> ##[1:5] ahb_rsp.hreadyout)
      else $error("transfer wait too long");
   a_data_stand: assert property
      (ahb_rsp.hreadyout && !taken |=> $stable(ahb_rsp.hrdata))
      else $error("read data moved while idle");
   a_evt_onehot: assert property ($onehot0(evt))
      else $error("two control events at once");
   a_evt_single: assert property ((|evt) |=> !(|evt))
      else $error("control event longer than one cycle");
   a_brk_cause: assert property
      (evt.brk |-> $past(ahb_req.hwdata[4:0]) == cxu_pkg::OP_BREAK)
      else $error("break event without break command");
   a_sleep_cause: assert property
      (evt.sleep |-> $past(ahb_req.hwdata[4:0]) == cxu_pkg::OP_SLEEP)
      else $error("sleep event without sleep command");
   a_wdr_cause: assert property
      (evt.watchdog_restart |->
       $past(ahb_req.hwdata[4:0]) == cxu_pkg::OP_WATCHDOG_RESTART)
      else $error("watchdog event without its command");
endmodule : cxu_core_assertions

bind cxu_core cxu_core_assertions i_cxu_core_assertions (
   .clk_sys(clk_sys), .reset(reset), .ahb_req(ahb_req),
   .ahb_rsp(ahb_rsp), .evt(evt));
`default_nettype wire

// >>> verif/cxu_core_tb.sv
// self-checking bench: commands go in over the register bus
// assumes the bus master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module cxu_core_tb;
   logic                  clk_sys;
   logic                  reset;
   cxu_pkg::cxu_ahb_req_s ahb_req;
   cxu_pkg::cxu_ahb_rsp_s ahb_rsp;
   cxu_pkg::cxu_evt_s     evt;
   int                    n_mismatch;
   int                    samples_checked;
   logic [31:0]           rd_q;
   logic [2:0]            evt_seen;   // control pulses seen since reset
   int                    n_low = 0;  // edges sampled with hreadyout low
   int                    w0;         // n_low just before an access
   // memory after exchange, or, clear, toggle of c3 with 5a
   logic [7:0] mres [4] = '{8'h5A, 8'hDB, 8'h81, 8'h99};
   // shift ops on 96 with flags 71: result and flags
   logic [4:0] sop [6] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E};
   logic [7:0] sres [6] = '{8'h2C, 8'h4B, 8'h2D, 8'hCB, 8'hCB, 8'h69};
   logic [7:0] sflg [6] = '{8'h59, 8'h70, 8'h59, 8'h7C, 8'h7C, 8'h71};

   cxu_core i_cxu_core (.clk_sys(clk_sys), .reset(reset),
      .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .evt(evt));
   cxu_ahb_master i_cxu_ahb_master (.clk_sys(clk_sys),
      .ahb_req(ahb_req), .ahb_rsp(ahb_rsp));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // collect control pulses and wait states; the bus alone cannot
   // show a long instruction except through the stall it causes
   always @(posedge clk_sys) begin
      if (reset) evt_seen <= 3'h0;
      else evt_seen <= evt_seen | evt;
      if (ahb_rsp.hreadyout === 1'b0) n_low <= n_low + 1;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk

   // byte register access; upper bits must read zero
   task automatic wr(logic [11:0] a, logic [7:0] d);
      i_cxu_ahb_master.xfer(1'b1, {20'h0, a}, {24'h0, d}, rd_q);
   endtask : wr
   task automatic rc(string what, logic [11:0] a, logic [7:0] e);
      i_cxu_ahb_master.xfer(1'b0, {20'h0, a}, 32'h0, rd_q);
      chk(what, rd_q, {24'h0, e});
   endtask : rc
   // issue one instruction through the command word
   task automatic ex(logic [4:0] op, logic [4:0] r, logic [5:0] a,
                     logic [2:0] b);
      i_cxu_ahb_master.xfer(1'b1, 32'h0, {13'h0, b, a, r, op}, rd_q);
   endtask : ex
   function automatic logic [11:0] gr(logic [4:0] r);
      return 12'h100 + {5'h0, r, 2'b00};
   endfunction : gr
   function automatic logic [11:0] io(logic [5:0] a);
      return 12'h200 + {4'h0, a, 2'b00};
   endfunction : io
   function automatic logic [11:0] dm(logic [7:0] m);
      return 12'h400 + {2'h0, m, 2'b00};
   endfunction : dm

   ////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      n_mismatch = 0;
      samples_checked = 0;
      rd_q = '0;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      rc("flags rst", 12'h004, 8'h00);
      rc("sptr rst", 12'h00C, 8'hFF);
      rc("ctrl rst", 12'h010, 8'h00);
      wr(12'h180, 8'h5A);
      rc("unmapped", 12'h180, 8'h00);
      // i/o transfers keep preset flags
      wr(12'h004, 8'h5A);
      wr(io(6'h05), 8'hA5);
      ex(cxu_pkg::OP_IO_READ, 5'h03, 6'h05, 3'h0);
      rc("io read", gr(5'h03), 8'hA5);
      ex(cxu_pkg::OP_IO_WRITE, 5'h03, 6'h07, 3'h0);
      rc("io write", io(6'h07), 8'hA5);
      // push then pop, normal then external timing
      wr(gr(5'h04), 8'h3C);
      ex(cxu_pkg::OP_STACK_PUSH, 5'h04, 6'h00, 3'h0);
      rc("push mem", dm(8'hFF), 8'h3C);
      rc("push sp", 12'h00C, 8'hFE);
      ex(cxu_pkg::OP_STACK_POP, 5'h06, 6'h00, 3'h0);
      w0 = n_low;
      rc("pop reg", gr(5'h06), 8'h3C);
      chk("pop wait", n_low - w0, 32'h0000_0001);
      rc("pop sp", 12'h00C, 8'hFF);
      rc("flags kept", 12'h004, 8'h5A);
      wr(12'h010, 8'h01);
      wr(gr(5'h04), 8'h77);
      ex(cxu_pkg::OP_STACK_PUSH, 5'h04, 6'h00, 3'h0);
      ex(cxu_pkg::OP_STACK_POP, 5'h09, 6'h00, 3'h0);
      w0 = n_low;
      rc("ext pop", gr(5'h09), 8'h77);
      chk("ext wait", n_low - w0, 32'h0000_0003);
      wr(12'h010, 8'h00);
      // atomic memory ops at z
      for (int i = 0; i < 4; i++) begin
         wr(12'h008, 8'h10);
         wr(dm(8'h10), 8'hC3);
         wr(gr(5'h02), 8'h5A);
         ex(5'h05 + 5'(i), 5'h02, 6'h00, 3'h0);
         rc("atomic reg", gr(5'h02), 8'hC3);
         rc("atomic mem", dm(8'h10), mres[i]);
      end
      // shifts, rotates and swap
      for (int i = 0; i < 6; i++) begin
         wr(gr(5'h05), 8'h96);
         wr(12'h004, 8'h71);
         ex(sop[i], 5'h05, 6'h00, 3'h0);
         rc("shift res", gr(5'h05), sres[i]);
         rc("shift flg", 12'h004, sflg[i]);
      end
      // every flag set and cleared alone
      for (int i = 0; i < 8; i++) begin
         wr(12'h004, 8'h00);
         ex(cxu_pkg::OP_FLAG_BIT_SET, 5'h00, 6'h00, 3'(i));
         rc("flag set", 12'h004, 8'h01 << i);
         wr(12'h004, 8'hFF);
         ex(cxu_pkg::OP_FLAG_BIT_CLEAR, 5'h00, 6'h00, 3'(i));
         rc("flag clr", 12'h004, ~(8'h01 << i));
      end
      // i/o bit set and clear
      wr(io(6'h09), 8'h0F);
      ex(cxu_pkg::OP_SET_IO_BIT, 5'h00, 6'h09, 3'h6);
      rc("io bit set", io(6'h09), 8'h4F);
      ex(cxu_pkg::OP_CLEAR_IO_BIT, 5'h00, 6'h09, 3'h0);
      rc("io bit clr", io(6'h09), 8'h4E);
      // t flag transfers
      wr(12'h004, 8'h00);
      wr(gr(5'h07), 8'h08);
      ex(cxu_pkg::OP_STORE_BIT_TO_T, 5'h07, 6'h00, 3'h3);
      rc("bit to t", 12'h004, 8'h40);
      wr(gr(5'h08), 8'h00);
      ex(cxu_pkg::OP_LOAD_BIT_FROM_T, 5'h08, 6'h00, 3'h1);
      rc("t to bit", gr(5'h08), 8'h02);
      // control instructions leave flags alone
      wr(12'h004, 8'hA5);
      for (int i = 0; i < 4; i++) begin
         ex((i == 3) ? 5'h00 : 5'h15 + 5'(i), 5'h00, 6'h00, 3'h0);
         rc("ctl flags", 12'h004, 8'hA5);
      end
      chk("ctl events", {29'h0, evt_seen}, 32'h0000_0007);
      conclude();
   end

   // hang guard, well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      conclude();
   end
endmodule : cxu_core_tb
`default_nettype wire
